// [rtl/pxc_ctrl_regs.v]
// Extended control register bank: three 16-bit registers and their controls.
//
// Summary of operation
// - Polarity inhibit set stops automatic receive polarity correction.
// - Heartbeat inhibit stops the SQE test, squelch inhibit stops squelch.
// - With link loss inhibit set the 10 Mb/s link always reports pass.
// - Speed source 0 uses the control speed bit, 1 the pin; strap reset.
// - Bank field steers upper addresses; 00 and 1x mean bank zero; reset 00.
// - Tri-state bit puts the twisted-pair line outputs in high impedance.
// - Auto power-down bit, reset one, lets the 100 Mb/s path power down.
// - Output strength bit, reset zero, selects enhanced low-voltage drive.
//
////////////////////////////////////////////////////////////////////////////
// Register map, as seen by the management entity.
// 0x12, ten-megabit operations:
//   [15:4] read as zero, owned by other logic; writes are ignored.
//   [3] receive polarity correction inhibit, reset 0.
//   [2] heartbeat test inhibit, reset 0.
//   [1] link loss inhibit, reset 0.
//   [0] squelch inhibit, reset 0.
// 0x13, extended control A:
//   [15] repeater mode, loaded from a strap after reset.
//   [14] speed source select, loaded from a strap after reset.
//   [13] remote fault, the live synchronised status, read only.
//   [12:11] bank select, reset 00; only code 01 selects bank one.
//   [10] reserved, reads zero, read only.
//   [9] crossover automatic enable, reset 1.
//   [8] crossover manual select, reset 0.
//   [7] twisted-pair tri-state, reset 0.
//   [6:1] reserved storage, reset 0.
//   [0] automatic 100 Mb/s power-down, reset 1.
// 0x14, extended control B:
//   [15] enhanced output strength, reset 0.
//   [14] fast-off enable, reset 0.
//   [13:12] LED4 mode, reset 11.
//   [11:0] stored here for the LED logic elsewhere, reset per constant.
// Any other address reads zero and ignores writes.
//
// Read data is registered, so it follows the address by one clock; a
// master must hold the address across one edge before it takes the data.
// This costs a cycle of latency but keeps the wide read mux off the
// output timing path.
//
// Straps are sampled only once after reset, so a strap that moves later
// has no effect until the next reset. A write in the same cycle as the
// strap load wins, so software written from then on is never overridden.
////////////////////////////////////////////////////////////////////////////
`include "pxc_defs.vh"
module pxc_ctrl_regs (
    input wire core_clk,
    input wire nrst,
    input wire [4:0] reg_addr,
    input wire reg_wr,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    input wire ctl_speed_bit,
    input wire speed_pin,
    input wire strap_speed_src,
    input wire strap_node_mode,
    input wire link_pulse_ok,
    input wire remote_fault,
    output wire polarity_autocorrect_en,
    output wire sqe_test_en,
    output wire squelch_en,
    output wire link_pass,
    output wire speed_100,
    output wire [1:0] bank_sel,
    output wire bank_is_one,
    output wire twisted_pair_tristate,
    output wire crossover_auto_enable,
    output wire crossover_manual_select,
    output wire repeater_mode,
    output wire auto_pd_100_en,
    output wire drive_enhance,
    output wire fast_off_en,
    output wire [1:0] led4_mode
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: speed pin, straps and live status are asynchronous.
    reg [4:0] sync1_q;
    reg [4:0] sync2_q;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= {remote_fault, link_pulse_ok, strap_node_mode,
                        strap_speed_src, speed_pin};
            sync2_q <= sync1_q;
        end
    end

    // Named views of the second synchroniser stage; nothing reads the first.
    wire speed_pin_s;
    wire strap_speed_src_s;
    wire strap_node_mode_s;
    wire link_pulse_ok_s;
    wire remote_fault_s;
    assign speed_pin_s = sync2_q[0];
    assign strap_speed_src_s = sync2_q[1];
    assign strap_node_mode_s = sync2_q[2];
    assign link_pulse_ok_s = sync2_q[3];
    assign remote_fault_s = sync2_q[4];

    // Straps are captured once, on the third edge after reset release, so
    // the asynchronous reset itself only loads constants.
    reg strap_done_q;
    reg [1:0] strap_wait_q;
    wire strap_load;
    assign strap_load = !strap_done_q && (strap_wait_q == `PXC_STRAP_WAIT);
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            strap_done_q <= 1'b0;
            strap_wait_q <= 2'h0;
        end else begin
            if (strap_wait_q != `PXC_STRAP_WAIT)
                strap_wait_q <= strap_wait_q + 2'h1;
            if (strap_load)
                strap_done_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write strobes, one per register address.
    wire wr_tenbt;
    wire wr_exta;
    wire wr_extb;
    assign wr_tenbt = reg_wr && (reg_addr == `PXC_OFS_TENBT);
    assign wr_exta = reg_wr && (reg_addr == `PXC_OFS_EXTA);
    assign wr_extb = reg_wr && (reg_addr == `PXC_OFS_EXTB);

    ////////////////////////////////////////////////////////////////////////
    // Register instances.
    wire [15:0] tenbt_q;
    wire [15:0] exta_q;
    wire [15:0] extb_q;
    wire [15:0] exta_strap_mask;
    wire [15:0] exta_strap_val;
    assign exta_strap_mask = (16'h0001 << `PXC_BIT_SPDSRC)
                           | (16'h0001 << `PXC_BIT_NODE);
    assign exta_strap_val = ({15'h0000, strap_speed_src_s} << `PXC_BIT_SPDSRC)
                          | ({15'h0000, strap_node_mode_s} << `PXC_BIT_NODE);

    pxc_reg16 #(.RST_VAL(`PXC_RST_TENBT), .WMASK(`PXC_WMASK_TENBT)) u_tenbt (
        .core_clk(core_clk),
        .nrst(nrst),
        .wr_en(wr_tenbt),
        .wr_data(reg_wdata),
        .strap_load(1'b0),
        .strap_mask(16'h0000),
        .strap_val(16'h0000),
        .val_q(tenbt_q)
    );

    pxc_reg16 #(.RST_VAL(`PXC_RST_EXTA), .WMASK(`PXC_WMASK_EXTA)) u_exta (
        .core_clk(core_clk),
        .nrst(nrst),
        .wr_en(wr_exta),
        .wr_data(reg_wdata),
        .strap_load(strap_load),
        .strap_mask(exta_strap_mask),
        .strap_val(exta_strap_val),
        .val_q(exta_q)
    );

    pxc_reg16 #(.RST_VAL(`PXC_RST_EXTB), .WMASK(`PXC_WMASK_EXTB)) u_extb (
        .core_clk(core_clk),
        .nrst(nrst),
        .wr_en(wr_extb),
        .wr_data(reg_wdata),
        .strap_load(1'b0),
        .strap_mask(16'h0000),
        .strap_val(16'h0000),
        .val_q(extb_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read path. Bits 15:4 of the first register belong to other logic and
    // read as zero here; the remote fault bit shows the live status.
    wire [15:0] exta_view;
    assign exta_view = (exta_q & `PXC_WMASK_EXTA)
                     | ({15'h0000, remote_fault_s} << `PXC_BIT_RFAULT);
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            reg_rdata <= 16'h0000;
        else begin
            case (reg_addr)
                `PXC_OFS_TENBT: reg_rdata <= tenbt_q & `PXC_WMASK_TENBT;
                `PXC_OFS_EXTA: reg_rdata <= exta_view;
                `PXC_OFS_EXTB: reg_rdata <= extb_q;
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control outputs.
    assign polarity_autocorrect_en = !tenbt_q[`PXC_BIT_POL_INH];
    assign sqe_test_en = !tenbt_q[`PXC_BIT_SQE_INH];
    assign squelch_en = !tenbt_q[`PXC_BIT_SQUELCH_INH];
    assign link_pass = tenbt_q[`PXC_BIT_LINKLOSS_INH] | link_pulse_ok_s;
    assign speed_100 = exta_q[`PXC_BIT_SPDSRC] ? speed_pin_s
                                               : ctl_speed_bit;
    assign bank_sel = exta_q[`PXC_BIT_BANK_HI:`PXC_BIT_BANK_LO];
    // Only code 01 selects bank one; 00 and 1x both fall to bank zero.
    assign bank_is_one = (bank_sel == 2'h1);
    assign twisted_pair_tristate = exta_q[`PXC_BIT_TWISTED_PAIR_TRISTATE];
    assign crossover_auto_enable = exta_q[`PXC_BIT_XAUTO];
    assign crossover_manual_select = exta_q[`PXC_BIT_XMANUAL];
    assign repeater_mode = exta_q[`PXC_BIT_NODE];
    assign auto_pd_100_en = exta_q[`PXC_BIT_APD];
    assign drive_enhance = extb_q[`PXC_BIT_STRENH];
    assign fast_off_en = extb_q[`PXC_BIT_FASTOFF];
    assign led4_mode = extb_q[`PXC_BIT_LED4_HI:`PXC_BIT_LED4_LO];
endmodule

// [rtl/pxc_defs.vh]
// Register offsets, field positions and reset values for the control bank.
`ifndef PXC_DEFS_VH
`define PXC_DEFS_VH
`define PXC_ADDR_W 5
`define PXC_OFS_TENBT 5'h12
`define PXC_OFS_EXTA 5'h13
`define PXC_OFS_EXTB 5'h14
`define PXC_BIT_SQUELCH_INH 0
`define PXC_BIT_LINKLOSS_INH 1
`define PXC_BIT_SQE_INH 2
`define PXC_BIT_POL_INH 3
`define PXC_BIT_APD 0
`define PXC_BIT_TWISTED_PAIR_TRISTATE 7
`define PXC_BIT_XMANUAL 8
`define PXC_BIT_XAUTO 9
`define PXC_BIT_BANK_LO 11
`define PXC_BIT_BANK_HI 12
`define PXC_BIT_RFAULT 13
`define PXC_BIT_SPDSRC 14
`define PXC_BIT_NODE 15
`define PXC_BIT_FASTOFF 14
`define PXC_BIT_STRENH 15
`define PXC_BIT_LED4_LO 12
`define PXC_BIT_LED4_HI 13
// Edges after reset release before the straps are taken into the bank.
`define PXC_STRAP_WAIT 2'h2
// Writable bit masks; all other bits are read-only.
`define PXC_WMASK_TENBT 16'h000F
`define PXC_WMASK_EXTA 16'hDBFF
`define PXC_WMASK_EXTB 16'hFFFF
// Reset values; strap-loaded bits are overlaid after reset release.
`define PXC_RST_TENBT 16'h0000
`define PXC_RST_EXTA 16'h0201
`define PXC_RST_EXTB 16'h3000
`endif

// [rtl/pxc_reg16.v]
// One 16-bit management register with per-bit write mask and strap load.
module pxc_reg16 #(
    parameter [15:0] RST_VAL = 16'h0000,
    parameter [15:0] WMASK = 16'hFFFF
) (
    input wire core_clk,
    input wire nrst,
    input wire wr_en,
    input wire [15:0] wr_data,
    input wire strap_load,
    input wire [15:0] strap_mask,
    input wire [15:0] strap_val,
    output reg [15:0] val_q
);
    reg [15:0] val_d;

    always @* begin
        val_d = val_q;
        if (strap_load)
            val_d = (val_q & ~strap_mask) | (strap_val & strap_mask);
        if (wr_en)
            val_d = (val_q & ~WMASK) | (wr_data & WMASK);
    end

    always @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            val_q <= RST_VAL;
        else
            val_q <= val_d;
    end
endmodule

// [test/pxc_ctrl_regs_assertions.sv]
// Concurrent checks on the ports of the control register bank.
module pxc_ctrl_regs_assertions (
    input wire core_clk,
    input wire nrst,
    input wire [4:0] reg_addr,
    input wire reg_wr,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire polarity_autocorrect_en,
    input wire sqe_test_en,
    input wire squelch_en,
    input wire link_pass,
    input wire [1:0] bank_sel,
    input wire bank_is_one,
    input wire twisted_pair_tristate,
    input wire auto_pd_100_en,
    input wire drive_enhance
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    wire w12 = reg_wr && reg_addr == 5'h12;
    wire w13 = reg_wr && reg_addr == 5'h13;
    wire w14 = reg_wr && reg_addr == 5'h14;
    ////////////////////////////////////////
    AST_POL: assert property (w12 |=>
        polarity_autocorrect_en == !$past(reg_wdata[3]))
        else $error("polarity enable wrong");
    AST_SQE: assert property (w12 |=>
        sqe_test_en == !$past(reg_wdata[2])) else $error("sqe enable wrong");
    AST_SQL: assert property (w12 |=>
        squelch_en == !$past(reg_wdata[0])) else $error("squelch wrong");
    AST_LINK: assert property (w12 && reg_wdata[1] |=> link_pass)
        else $error("link not forced");
    AST_BANK: assert property (w13 |=>
        bank_sel == $past(reg_wdata[12:11]) &&
        bank_is_one == ($past(reg_wdata[12:11]) == 2'h1))
        else $error("bank select wrong");
    AST_TRI: assert property (w13 |=>
        twisted_pair_tristate == $past(reg_wdata[7]))
        else $error("tristate wrong");
    AST_APD: assert property (w13 |=>
        auto_pd_100_en == $past(reg_wdata[0])) else $error("power-down wrong");
    AST_STR: assert property (w14 |=>
        drive_enhance == $past(reg_wdata[15])) else $error("strength wrong");
    // Unmapped places must read zero once the address has settled.
    AST_UNMAP: assert property (!(reg_addr inside {5'h12, 5'h13, 5'h14})
        && $stable(reg_addr) |-> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    cover property (w12 && reg_wdata[1]);
    cover property (w13 && reg_wdata[7]);
    cover property (reg_wr ##1 reg_wr);
endmodule

// [test/pxc_ctrl_regs_bench.sv]
// Self-checking bench for the extended control register bank.
module pxc_ctrl_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 0, nrst = 0, ctl_speed_bit = 0, speed_pin = 0;
    logic strap_speed_src = 0, strap_node_mode = 0;
    logic link_pulse_ok = 0, remote_fault = 0;
    wire [4:0] reg_addr;
    wire reg_wr;
    wire [15:0] reg_wdata, reg_rdata;
    wire polarity_autocorrect_en, sqe_test_en, squelch_en, link_pass;
    wire speed_100, bank_is_one, twisted_pair_tristate, repeater_mode;
    wire crossover_auto_enable, crossover_manual_select, auto_pd_100_en;
    wire drive_enhance, fast_off_en;
    wire [1:0] bank_sel, led4_mode;
    logic [15:0] m0, m1, m2, r, v;
    logic [16:0] cs, ce;
    logic [4:0] a;
    int err_count = 0, n_checks = 0, cyc = 0;
    always #2 core_clk = ~core_clk;
    pxc_sta_model sta (.core_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata);
    pxc_ctrl_regs dut (.core_clk, .nrst, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rdata, .ctl_speed_bit, .speed_pin, .strap_speed_src,
        .strap_node_mode, .link_pulse_ok, .remote_fault,
        .polarity_autocorrect_en, .sqe_test_en, .squelch_en, .link_pass,
        .speed_100, .bank_sel, .bank_is_one, .twisted_pair_tristate,
        .crossover_auto_enable, .crossover_manual_select, .repeater_mode,
        .auto_pd_100_en, .drive_enhance, .fast_off_en, .led4_mode);
    ////////////////////////////////////////
    function [15:0] nx(input [15:0] s);
        nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function [15:0] exp_rd(input [4:0] x);
        exp_rd = x == 5'h12 ? m0 & 16'h000F : x == 5'h14 ? m2 :
            x == 5'h13 ? m1 & 16'hDBFF | {2'h0, remote_fault, 13'h0} : 0;
    endfunction
    task chk(input string nm, input [17:0] s, input [17:0] e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task outs;
        cs = {polarity_autocorrect_en, sqe_test_en, squelch_en,
            link_pass, speed_100, bank_sel, bank_is_one, twisted_pair_tristate,
            crossover_auto_enable, crossover_manual_select, repeater_mode,
            auto_pd_100_en, drive_enhance, fast_off_en, led4_mode};
        ce = {~m0[3], ~m0[2], ~m0[0], m0[1] | link_pulse_ok,
            m1[14] ? speed_pin : ctl_speed_bit, m1[12:11], m1[12:11] == 2'h1,
            m1[7], m1[9], m1[8], m1[15], m1[0], m2[15:12]};
        chk("controls", cs, ce);
    endtask
    task complete_run;
        if (err_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            complete_run;
        end
    end
    initial begin
        r = 16'h005F;
        for (int p = 0; p < 2; p++) begin
            // The second pass resets in mid-run, after traffic.
            r = nx(r);
            {strap_speed_src, strap_node_mode} = r[1:0];
            nrst = 0;
            repeat (10) @(posedge core_clk);
            #1 nrst = 1;
            repeat (4) @(posedge core_clk);
            m0 = 16'h0000;
            m1 = 16'h0201 | {strap_node_mode, strap_speed_src, 14'h0};
            m2 = 16'h3000;
            for (int i = 0; i < 4; i++) begin
                sta.rd(5'h12 + i, v);
                chk("reset read", v, exp_rd(5'h12 + i));
            end
            outs();
            for (int i = 0; i < 12; i++) begin
                r = nx(r);
                {ctl_speed_bit, speed_pin} = r[3:2];
                {link_pulse_ok, remote_fault} = r[1:0];
                a = 5'h12 + r[5:4];
                r = nx(r);
                v = {r[15:13], i[1:0], r[10:0]};
                sta.wr(a, v);
                m0 = a == 5'h12 ? v : m0;
                m1 = a == 5'h13 ? v & 16'hDBFF : m1;
                m2 = a == 5'h14 ? v : m2;
                if (r[0]) begin
                    sta.wr(5'h13, ~v);
                    m1 = ~v & 16'hDBFF;
                end
                sta.rd(a, v);
                chk("read back", v, exp_rd(a));
                outs();
            end
        end
        complete_run;
    end
endmodule
bind pxc_ctrl_regs pxc_ctrl_regs_assertions chk_i (.core_clk, .nrst,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .polarity_autocorrect_en,
    .sqe_test_en, .squelch_en, .link_pass, .bank_sel, .bank_is_one,
    .twisted_pair_tristate, .auto_pd_100_en, .drive_enhance);

// [test/pxc_sta_model.sv]
// Management entity model issuing register writes and reads.
module pxc_sta_model (
    input wire core_clk,
    input wire [15:0] reg_rdata,
    output logic [4:0] reg_addr,
    output logic reg_wr,
    output logic [15:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        reg_addr = 5'h00;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
    end
    ////////////////////////////////////////
    task wr(input [4:0] a, input [15:0] d);
        @(posedge core_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
    endtask
    // Released data shows its inverse so a stale value cannot pass.
    task rd(input [4:0] a, output [15:0] d);
        @(posedge core_clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~reg_wdata;
        reg_addr = a;
        @(posedge core_clk);
        #1;
        d = reg_rdata;
    endtask
endmodule
